// file: core/tbid_core.v
// Summary of operation
// - destination bit 0 writes accumulator, 1 writes the file register
// - add, file minus accumulator: one cycle, carry, half carry, zero
// - AND accumulator with file register, result per destination, zero only
// - inclusive and exclusive OR with file register, zero flag only
// - decrement, increment set zero; skip forms skip on zero, no flags
// - rotate left and right through carry, only carry changes
// - clear file, clear accumulator, store, move, complement, nibble swap
// - bit clear on selected bit of file register, no flags
// - bit set on selected bit of file register, no flags
// - bit test skips next when bit clear or set, no flags
// - AND literal into accumulator, zero flag updated
// - OR and XOR literal set zero; load literal changes no flag
// - return with literal and subroutine call take two cycles
// - jump carries nine-bit target, two cycles, no flags
// - standby, watchdog clear, option load, no operation decoded
// - every program counter write except jump forces bit eight low
// - port reads use pin levels, not the output latch
// - direction load with field 6 copies accumulator to direction latches
// - marked writes to timer register clear prescaler when assigned
// - five-bit file address and three-bit bit position fields
// - one instruction cycle is four clocks; flow changes take two cycles
// - met skip discards fetched instruction, executes no operation instead
`timescale 1ns/1ns
`default_nettype none
`include "tbid_core_regs.vh"

module tbid_core (
	input  wire        CLK,
	input  wire        RESET_N,
	input  wire [11:0] INSTR,
	output wire [8:0]  PROG_ADDR,
	output wire [4:0]  FILE_ADDR,
	input  wire [7:0]  FILE_RDATA,
	output reg  [4:0]  FILE_WADDR,
	output reg  [7:0]  FILE_WDATA,
	output reg         FILE_WE,
	input  wire [7:0]  PORT_PINS,
	output reg  [7:0]  DIR_LATCH,
	output reg         STACK_PUSH,
	output reg  [8:0]  PUSH_ADDR,
	output reg         STACK_POP,
	input  wire [7:0]  RETURN_ADDR,
	output reg  [7:0]  ACC,
	output reg         CARRY,
	output reg         HALF_CARRY,
	output reg         ZERO,
	output reg         TIMEOUT_FLAG,
	output reg         POWERDOWN_FLAG,
	output reg  [7:0]  OPTION_DATA,
	output reg         OPTION_WE,
	output reg         SLEEP_REQ,
	output reg         WDT_CLEAR,
	input  wire        PRESCALER_ON_TIMER,
	output reg         PRESCALER_CLEAR
);

	reg  [1:0]  phase_q;
	reg  [8:0]  pc_q;
	reg  [11:0] ir_q;
	reg         flush_q;
	reg  [7:0]  pins_s1_q, pins_s2_q;
	wire        exec, dest_f, marked, pcl_wr;
	wire [2:0]  b_sel;
	wire [4:0]  f_addr, hsum, hdiff;
	wire [7:0]  lit, fop, bmask;
	wire [8:0]  sum, diff, pc_inc, pc_d;
	reg  [7:0]  res;
	reg  [8:0]  tgt;
	reg         wr_acc, wr_f, upd_z, upd_c, upd_hc, c_new, hc_new;
	reg         skip, jump, push, pop, dir_ld, opt_ld, slp, wdt;

	assign exec   = (phase_q == `TBID_PHASE_LAST);
	assign f_addr = ir_q[`TBID_F_MSB:0];
	assign b_sel  = ir_q[`TBID_B_MSB:`TBID_B_LSB];
	assign lit    = ir_q[`TBID_K_MSB:0];
	assign dest_f = ir_q[`TBID_D_BIT];
	assign marked = (ir_q[11:6] != 6'h09); // complement only unmarked
	assign FILE_ADDR = f_addr;
	assign PROG_ADDR = pc_q;
	assign pc_inc = pc_q + 9'h001;

	// port reads take the synchronised pin levels
	assign fop = (f_addr == `TBID_ADDR_PORT) ? pins_s2_q : FILE_RDATA;
	assign bmask = 8'h01 << b_sel;

	// add and subtract with carry out of bit seven and bit three
	assign sum   = {1'b0, ACC} + {1'b0, fop};
	assign hsum  = {1'b0, ACC[3:0]} + {1'b0, fop[3:0]};
	assign diff  = {1'b0, fop} + {1'b0, ~ACC} + 9'h001;
	assign hdiff = {1'b0, fop[3:0]} + {1'b0, ~ACC[3:0]} + 5'h01;

	// decode of the instruction held for execution
	always @* begin
		res    = 8'h00;
		wr_acc = 1'b0;
		wr_f   = 1'b0;
		upd_z  = 1'b0;
		upd_c  = 1'b0;
		upd_hc = 1'b0;
		c_new  = CARRY;
		hc_new = HALF_CARRY;
		skip   = 1'b0;
		jump   = 1'b0;
		tgt    = 9'h000;
		push   = 1'b0;
		pop    = 1'b0;
		dir_ld = 1'b0;
		opt_ld = 1'b0;
		slp    = 1'b0;
		wdt    = 1'b0;
		casez (ir_q)
		`TBID_OP_OPTION: begin
			opt_ld = 1'b1;
		end
		`TBID_OP_SLEEP: begin
			slp    = 1'b1;
		end
		`TBID_OP_WDTCLR: begin
			wdt    = 1'b1;
		end
		`TBID_OP_DIRLD: begin // no operation lands here too
			dir_ld = (ir_q[2:0] == `TBID_DIR_SEL);
		end
		`TBID_OP_CLRACC: begin
			wr_acc = 1'b1;
			upd_z  = 1'b1;
		end
		`TBID_OP_STORE: begin
			res  = ACC;
			wr_f = 1'b1;
		end
		`TBID_OP_CLEAR_FILE_OP: begin
			wr_f  = 1'b1;
			upd_z = 1'b1;
		end
		`TBID_OP_SUB: begin
			res    = diff[7:0];
			c_new  = diff[8];
			hc_new = hdiff[4];
			upd_c  = 1'b1;
			upd_hc = 1'b1;
			upd_z  = 1'b1;
			wr_f   = dest_f;
			wr_acc = ~dest_f;
		end
		`TBID_OP_ADD: begin
			res    = sum[7:0];
			c_new  = sum[8];
			hc_new = hsum[4];
			upd_c  = 1'b1;
			upd_hc = 1'b1;
			upd_z  = 1'b1;
			wr_f   = dest_f;
			wr_acc = ~dest_f;
		end
		`TBID_OP_DEC, `TBID_OP_INC: begin
			res    = ir_q[9] ? fop + 8'h01 : fop - 8'h01;
			upd_z  = 1'b1;
			wr_f   = dest_f;
			wr_acc = ~dest_f;
		end
		`TBID_OP_DECSZ, `TBID_OP_INCSZ: begin
			res    = ir_q[8] ? fop + 8'h01 : fop - 8'h01;
			skip   = (res == 8'h00);
			wr_f   = dest_f;
			wr_acc = ~dest_f;
		end
		`TBID_OP_IOR: begin
			res    = ACC | fop;
			upd_z  = 1'b1;
			wr_f   = dest_f;
			wr_acc = ~dest_f;
		end
		`TBID_OP_XOR: begin
			res    = ACC ^ fop;
			upd_z  = 1'b1;
			wr_f   = dest_f;
			wr_acc = ~dest_f;
		end
		`TBID_OP_AND: begin
			res    = ACC & fop;
			upd_z  = 1'b1;
			wr_f   = dest_f;
			wr_acc = ~dest_f;
		end
		`TBID_OP_MOVE_FILE_OP: begin
			res    = fop;
			upd_z  = 1'b1;
			wr_f   = dest_f;
			wr_acc = ~dest_f;
		end
		`TBID_OP_COMPLEMENT_FILE_OP: begin
			res    = ~fop;
			upd_z  = 1'b1;
			wr_f   = dest_f;
			wr_acc = ~dest_f;
		end
		`TBID_OP_SWAP: begin
			res    = {fop[3:0], fop[7:4]};
			wr_f   = dest_f;
			wr_acc = ~dest_f;
		end
		`TBID_OP_RL: begin
			res    = {fop[6:0], CARRY};
			c_new  = fop[7];
			upd_c  = 1'b1;
			wr_f   = dest_f;
			wr_acc = ~dest_f;
		end
		`TBID_OP_RR: begin
			res    = {CARRY, fop[7:1]};
			c_new  = fop[0];
			upd_c  = 1'b1;
			wr_f   = dest_f;
			wr_acc = ~dest_f;
		end
		`TBID_OP_BCLR: begin
			res  = fop & ~bmask;
			wr_f = 1'b1;
		end
		`TBID_OP_BSET: begin
			res  = fop | bmask;
			wr_f = 1'b1;
		end
		`TBID_OP_BTSC: begin
			skip   = ((fop & bmask) == 8'h00);
		end
		`TBID_OP_BTSS: begin
			skip   = ((fop & bmask) != 8'h00);
		end
		`TBID_OP_RETLIT: begin
			res    = lit;
			wr_acc = 1'b1;
			pop    = 1'b1;
			jump   = 1'b1;
			tgt    = {1'b0, RETURN_ADDR};
		end
		`TBID_OP_CALL: begin
			push   = 1'b1;
			jump   = 1'b1;
			tgt    = {1'b0, lit};
		end
		`TBID_OP_JUMP: begin
			jump   = 1'b1;
			tgt    = ir_q[`TBID_JK_MSB:0];
		end
		`TBID_OP_LDLIT: begin
			res    = lit;
			wr_acc = 1'b1;
		end
		`TBID_OP_ORLIT: begin
			res    = ACC | lit;
			wr_acc = 1'b1;
			upd_z  = 1'b1;
		end
		`TBID_OP_ANDLIT: begin
			res    = ACC & lit;
			wr_acc = 1'b1;
			upd_z  = 1'b1;
		end
		`TBID_OP_XORLIT: begin
			res    = ACC ^ lit;
			wr_acc = 1'b1;
			upd_z  = 1'b1;
		end
		default: ;
		endcase
	end

	// program counter writes through the low byte clear bit eight
	assign pcl_wr = wr_f && (f_addr == `TBID_ADDR_PCL);
	assign pc_d   = jump ? tgt : (pcl_wr ? {1'b0, res} : pc_inc);

	// pin synchroniser
	always @(posedge CLK) begin
		pins_s1_q <= PORT_PINS;
		pins_s2_q <= pins_s1_q;
	end

	// execution: one instruction per four clocks
	always @(posedge CLK) begin
		if (!RESET_N) begin
			phase_q        <= 2'h0;
			pc_q           <= `TBID_RESET_PC;
			ir_q           <= `TBID_OP_NOP;
			flush_q        <= 1'b1;
			ACC            <= 8'h00;
			CARRY          <= 1'b0;
			HALF_CARRY     <= 1'b0;
			ZERO           <= 1'b0;
			TIMEOUT_FLAG   <= 1'b1;
			POWERDOWN_FLAG <= 1'b1;
			DIR_LATCH      <= `TBID_DIR_RESET;
			OPTION_DATA    <= 8'h00;
			PUSH_ADDR      <= 9'h000;
			FILE_WADDR     <= 5'h00;
			FILE_WDATA     <= 8'h00;
			FILE_WE        <= 1'b0;
			STACK_PUSH     <= 1'b0;
			STACK_POP      <= 1'b0;
			OPTION_WE      <= 1'b0;
			SLEEP_REQ      <= 1'b0;
			WDT_CLEAR      <= 1'b0;
			PRESCALER_CLEAR <= 1'b0;
		end else begin
			phase_q         <= phase_q + 2'h1;
			FILE_WE         <= 1'b0;
			STACK_PUSH      <= 1'b0;
			STACK_POP       <= 1'b0;
			OPTION_WE       <= 1'b0;
			SLEEP_REQ       <= 1'b0;
			WDT_CLEAR       <= 1'b0;
			PRESCALER_CLEAR <= 1'b0;
			if (exec) begin
				ir_q <= INSTR;
				if (flush_q) begin
					pc_q    <= pc_inc;
					flush_q <= 1'b0;
				end else begin
					pc_q    <= pc_d;
					flush_q <= skip | jump | pcl_wr;
					if (wr_acc) begin
						ACC <= res;
					end
					if (upd_z) begin
						ZERO <= (res == 8'h00);
					end
					if (upd_c) begin
						CARRY <= c_new;
					end
					if (upd_hc) begin
						HALF_CARRY <= hc_new;
					end
					FILE_WE    <= wr_f;
					FILE_WADDR <= f_addr;
					FILE_WDATA <= res;
					PRESCALER_CLEAR <= wr_f && marked && PRESCALER_ON_TIMER
						&& (f_addr == `TBID_ADDR_TIMER);
					STACK_PUSH <= push;
					STACK_POP  <= pop;
					PUSH_ADDR  <= pc_q;
					if (dir_ld) begin
						DIR_LATCH <= ACC;
					end
					if (opt_ld) begin
						OPTION_DATA <= ACC;
					end
					OPTION_WE <= opt_ld;
					SLEEP_REQ <= slp;
					WDT_CLEAR <= wdt;
					if (wdt) begin
						TIMEOUT_FLAG   <= 1'b1;
						POWERDOWN_FLAG <= 1'b1;
					end
					if (slp) begin
						TIMEOUT_FLAG   <= 1'b1;
						POWERDOWN_FLAG <= 1'b0;
					end
				end
			end
		end
	end

endmodule
`default_nettype wire

// file: core/tbid_core_regs.vh
`ifndef TBID_CORE_REGS_VH
`define TBID_CORE_REGS_VH

// instruction cycle: four oscillator periods
`define TBID_PHASE_LAST 2'h3
`define TBID_RESET_PC   9'h000

// file register addresses
`define TBID_ADDR_TIMER 5'h01
`define TBID_ADDR_PCL   5'h02
`define TBID_ADDR_PORT  5'h06

// direction latch select and reset value (all pins high impedance)
`define TBID_DIR_SEL    3'h6
`define TBID_DIR_RESET  8'hff

// field positions
`define TBID_F_MSB      4
`define TBID_D_BIT      5
`define TBID_B_LSB      5
`define TBID_B_MSB      7
`define TBID_K_MSB      7
`define TBID_JK_MSB     8

// opcode patterns
`define TBID_OP_NOP     12'b0000_0000_0000
`define TBID_OP_OPTION  12'b0000_0000_0010
`define TBID_OP_SLEEP   12'b0000_0000_0011
`define TBID_OP_WDTCLR  12'b0000_0000_0100
`define TBID_OP_DIRLD   12'b0000_0000_0???
`define TBID_OP_CLRACC  12'b0000_0100_0000
`define TBID_OP_STORE   12'b0000_001?_????
`define TBID_OP_CLEAR_FILE_OP    12'b0000_011?_????
`define TBID_OP_SUB     12'b0000_10??_????
`define TBID_OP_DEC     12'b0000_11??_????
`define TBID_OP_IOR     12'b0001_00??_????
`define TBID_OP_AND     12'b0001_01??_????
`define TBID_OP_XOR     12'b0001_10??_????
`define TBID_OP_ADD     12'b0001_11??_????
`define TBID_OP_MOVE_FILE_OP    12'b0010_00??_????
`define TBID_OP_COMPLEMENT_FILE_OP    12'b0010_01??_????
`define TBID_OP_INC     12'b0010_10??_????
`define TBID_OP_DECSZ   12'b0010_11??_????
`define TBID_OP_RR      12'b0011_00??_????
`define TBID_OP_RL      12'b0011_01??_????
`define TBID_OP_SWAP    12'b0011_10??_????
`define TBID_OP_INCSZ   12'b0011_11??_????
`define TBID_OP_BCLR    12'b0100_????_????
`define TBID_OP_BSET    12'b0101_????_????
`define TBID_OP_BTSC    12'b0110_????_????
`define TBID_OP_BTSS    12'b0111_????_????
`define TBID_OP_RETLIT  12'b1000_????_????
`define TBID_OP_CALL    12'b1001_????_????
`define TBID_OP_JUMP    12'b101?_????_????
`define TBID_OP_LDLIT   12'b1100_????_????
`define TBID_OP_ORLIT   12'b1101_????_????
`define TBID_OP_ANDLIT  12'b1110_????_????
`define TBID_OP_XORLIT  12'b1111_????_????

`endif

// file: testbench/tbid_mem.sv
`timescale 1ns/1ns
`default_nettype none
module tbid_mem (
	input  wire logic        clk,
	input  wire logic [8:0]  prog_addr,
	output logic      [11:0] instr,
	input  wire logic [4:0]  file_addr,
	output logic      [7:0]  file_rdata,
	input  wire logic [4:0]  file_waddr,
	input  wire logic [7:0]  file_wdata,
	input  wire logic        file_we,
	input  wire logic        stack_push,
	input  wire logic [8:0]  push_addr,
	input  wire logic        stack_pop,
	output logic      [7:0]  return_addr
);
	logic [11:0] prog [0:511];
	logic [7:0]  regs [0:31];
	logic [8:0]  stk  [0:1];
	initial begin
		for (int i = 0; i < 32; i++) regs[i] = 8'h00;
	end
	assign instr = prog[prog_addr];
	assign file_rdata = regs[file_addr];
	assign return_addr = stk[0][7:0];
	// two-deep stack; a popped slot is spoiled, not kept
	always @(posedge clk) begin
		if (file_we) regs[file_waddr] <= file_wdata;
		if (stack_push) begin
			stk[0] <= push_addr;
			stk[1] <= stk[0];
		end else if (stack_pop) begin
			stk[0] <= stk[1];
			stk[1] <= ~stk[1];
		end
	end
endmodule
`default_nettype wire

// file: testbench/tbid_core_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "tbid_core_regs.vh"
module tbid_props (
	input wire logic       CLK,
	input wire logic       RESET_N,
	input wire logic [8:0] PROG_ADDR,
	input wire logic [4:0] FILE_ADDR,
	input wire logic [4:0] FILE_WADDR,
	input wire logic       FILE_WE,
	input wire logic [7:0] DIR_LATCH,
	input wire logic       STACK_PUSH,
	input wire logic [8:0] PUSH_ADDR,
	input wire logic       STACK_POP,
	input wire logic [7:0] RETURN_ADDR,
	input wire logic [7:0] ACC,
	input wire logic       TIMEOUT_FLAG,
	input wire logic       POWERDOWN_FLAG,
	input wire logic       OPTION_WE,
	input wire logic [7:0] OPTION_DATA,
	input wire logic       SLEEP_REQ,
	input wire logic       WDT_CLEAR,
	input wire logic       PRESCALER_ON_TIMER,
	input wire logic       PRESCALER_CLEAR
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	a_we_pulse: assert property (FILE_WE |=> !FILE_WE [*3])
		else $error("write strobe not a lone pulse");
	a_pc_hold: assert property ($changed(PROG_ADDR) |=>
		$stable(PROG_ADDR) [*3])
		else $error("pc moved inside an instruction cycle");
	a_we_addr: assert property (FILE_WE |-> FILE_WADDR == $past(FILE_ADDR))
		else $error("write address differs from operand field");
	a_push_pc: assert property (STACK_PUSH |->
		PUSH_ADDR == $past(PROG_ADDR) && !PROG_ADDR[8])
		else $error("call push or target wrong");
	a_pop_pc: assert property (STACK_POP |->
		PROG_ADDR == {1'b0, $past(RETURN_ADDR)})
		else $error("return target wrong");
	a_flow_flush: assert property ((STACK_PUSH || STACK_POP) |-> ##4
		!(FILE_WE || STACK_PUSH || STACK_POP || OPTION_WE))
		else $error("word after flow change not discarded");
	a_dir_load: assert property ($changed(DIR_LATCH) |-> DIR_LATCH == $past(ACC))
		else $error("direction latch not loaded from acc");
	a_option_load: assert property (OPTION_WE |-> OPTION_DATA == $past(ACC))
		else $error("option data not from acc");
	a_sleep_flags: assert property (SLEEP_REQ |-> TIMEOUT_FLAG && !POWERDOWN_FLAG)
		else $error("standby flags wrong");
	a_wdt_flags: assert property (WDT_CLEAR |-> TIMEOUT_FLAG && POWERDOWN_FLAG)
		else $error("watchdog clear flags wrong");
	a_timer_clear: assert property (PRESCALER_CLEAR |-> FILE_WE
		&& $past(PRESCALER_ON_TIMER) && FILE_WADDR == `TBID_ADDR_TIMER)
		else $error("prescaler clear without timer write");
	c_call: cover property (STACK_PUSH);
	c_return: cover property (STACK_POP);
	c_presc: cover property (PRESCALER_CLEAR);
endmodule
bind tbid_core tbid_props i_props (.CLK(CLK), .RESET_N(RESET_N),
	.PROG_ADDR(PROG_ADDR), .FILE_ADDR(FILE_ADDR), .FILE_WADDR(FILE_WADDR),
	.FILE_WE(FILE_WE), .DIR_LATCH(DIR_LATCH), .STACK_PUSH(STACK_PUSH),
	.PUSH_ADDR(PUSH_ADDR), .STACK_POP(STACK_POP), .RETURN_ADDR(RETURN_ADDR),
	.ACC(ACC), .TIMEOUT_FLAG(TIMEOUT_FLAG), .POWERDOWN_FLAG(POWERDOWN_FLAG),
	.OPTION_WE(OPTION_WE), .OPTION_DATA(OPTION_DATA), .SLEEP_REQ(SLEEP_REQ),
	.WDT_CLEAR(WDT_CLEAR), .PRESCALER_ON_TIMER(PRESCALER_ON_TIMER),
	.PRESCALER_CLEAR(PRESCALER_CLEAR));
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "tbid_core_regs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  port_pins = 8'h5a;
	logic        presc_on = 1'b1;
	logic [11:0] instr;
	logic [8:0]  prog_addr, push_addr;
	logic [4:0]  file_addr, file_waddr;
	logic [7:0]  file_rdata, file_wdata, dir_latch, return_addr, acc, opt;
	logic        file_we, push, pop, carry, hcarry, zero, tout, pdown;
	logic [11:0] exp_q [$];
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          n;
	always #50 clk = ~clk;
	tbid_core i_dut (.CLK(clk), .RESET_N(reset_n), .INSTR(instr),
		.PROG_ADDR(prog_addr), .FILE_ADDR(file_addr), .FILE_RDATA(file_rdata),
		.FILE_WADDR(file_waddr), .FILE_WDATA(file_wdata), .FILE_WE(file_we),
		.PORT_PINS(port_pins), .DIR_LATCH(dir_latch), .STACK_PUSH(push),
		.PUSH_ADDR(push_addr), .STACK_POP(pop), .RETURN_ADDR(return_addr),
		.ACC(acc), .CARRY(carry), .HALF_CARRY(hcarry), .ZERO(zero),
		.TIMEOUT_FLAG(tout), .POWERDOWN_FLAG(pdown), .OPTION_DATA(opt),
		.OPTION_WE(), .SLEEP_REQ(), .WDT_CLEAR(),
		.PRESCALER_ON_TIMER(presc_on), .PRESCALER_CLEAR());
	tbid_mem i_mem (.clk(clk), .prog_addr(prog_addr), .instr(instr),
		.file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we),
		.file_waddr(file_waddr), .file_wdata(file_wdata), .stack_push(push),
		.push_addr(push_addr), .stack_pop(pop), .return_addr(return_addr));
	task print_verdict;
		if (error_cnt == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// word at address, expected {zero, carry, half carry, acc} after its cycle
	task w(input logic [8:0] a, input logic [11:0] wd, input logic [11:0] e);
		i_mem.prog[a] = wd;
		exp_q.push_back(e);
	endtask
	initial begin
		for (n = 0; n < 512; n++) i_mem.prog[n] = 12'h000;
		w(9'h00, 12'hc3c, 12'h03c);
		w(9'h01, 12'h025, 12'h03c);
		w(9'h02, 12'hcc8, 12'h0c8);
		w(9'h03, 12'h1e5, 12'h3c8);
		w(9'h04, 12'h085, 12'h03c);
		w(9'h05, 12'h145, 12'h004);
		w(9'h06, 12'h186, 12'h05e);
		w(9'h07, 12'he00, 12'h400);
		w(9'h08, 12'hd81, 12'h081);
		w(9'h09, 12'hf81, 12'h400);
		w(9'h0a, 12'h0c5, 12'h003);
		w(9'h0b, 12'h0e5, 12'h003);
		w(9'h0c, 12'h345, 12'h006);
		w(9'h0d, 12'h325, 12'h206);
		w(9'h0e, 12'h2e5, 12'h206);
		w(9'h0f, 12'hc99, 12'h206);
		w(9'h10, 12'h3e5, 12'h206);
		w(9'h11, 12'h605, 12'h206);
		w(9'h12, 12'h705, 12'h206);
		w(9'h13, 12'hc77, 12'h206);
		w(9'h14, 12'h5e5, 12'h206);
		w(9'h15, 12'h405, 12'h206);
		w(9'h16, 12'h205, 12'h280);
		w(9'h17, 12'h245, 12'h27f);
		w(9'h18, 12'h385, 12'h208);
		w(9'h19, 12'h040, 12'h600);
		w(9'h1a, 12'h065, 12'h600);
		w(9'h1b, 12'hc0f, 12'h60f);
		w(9'h1c, 12'h006, 12'h60f);
		w(9'h1d, 12'h005, 12'h60f);
		w(9'h1e, 12'h002, 12'h60f);
		w(9'h1f, 12'h003, 12'h60f);
		w(9'h20, 12'h004, 12'h60f);
		w(9'h21, 12'h000, 12'h60f);
		w(9'h22, 12'h021, 12'h60f);
		w(9'h23, 12'h928, 12'h60f);
		w(9'h24, 12'hc11, 12'h60f);
		w(9'h28, 12'h8a5, 12'h6a5);
		w(9'h29, 12'h000, 12'h6a5);
		w(9'h24, 12'hc11, 12'h611);
		w(9'h25, 12'hbf0, 12'h611);
		w(9'h26, 12'h000, 12'h611);
		w(9'h1f0, 12'hf55, 12'h244);
		repeat (12) @(posedge clk);
		#1;
		`CHK({acc, dir_latch, tout, pdown}, {8'h00, `TBID_DIR_RESET, 2'h3});
		`CHK(prog_addr, `TBID_RESET_PC);
		@(posedge clk);
		reset_n <= 1'b1;
		n = 0;
		while (prog_addr !== 9'h001 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 20) begin
			error_cnt++;
		end else begin
			foreach (exp_q[i]) begin
				repeat (4) @(posedge clk);
				#1;
				`CHK({1'b0, zero, carry, hcarry, acc}, exp_q[i]);
			end
			`CHK(i_mem.regs[5], 8'h00);
			`CHK(i_mem.regs[1], 8'h0f);
			`CHK({dir_latch, opt}, 16'h0f0f);
			`CHK({tout, pdown}, 2'h3);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
